/* File: core/prc_consts.svh */
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH
`define PRC_ADDR_W 5
`define PRC_DATA_W 16
`define PRC_A_ORDER 5'h00
`define PRC_A_TC 5'h01
`define PRC_A_WIN 5'h02
`define PRC_A_SETTLE 5'h03
`define PRC_A_ALLOC 5'h04
`define PRC_A_MODE 5'h05
`define PRC_A_MAP0 5'h06
`define PRC_A_MAP1 5'h07
`define PRC_A_MAP2 5'h08
`define PRC_A_MAP3 5'h09
`define PRC_A_INV0 5'h0A
`define PRC_A_INV1 5'h0B
`define PRC_A_INV2 5'h0C
`define PRC_A_INV3 5'h0D
`define PRC_A_LOWEN 5'h0E
`define PRC_A_HIGHEN 5'h0F
`define PRC_A_VIRT 5'h10
`define PRC_A_SRC 5'h11
`define PRC_A_RESTART 5'h12
`define PRC_A_STATUS 5'h13
`define PRC_A_ERR 5'h14
`define PRC_A_TCACT 5'h15
`define PRC_ORDER_DEF 1'h0
`define PRC_TC_DEF 15'h0000
`define PRC_WIN_DEF 16'h000A
`define PRC_SETTLE_DEF 16'h01F4
`define PRC_MODE_DEF 4'h0
`define PRC_MODE_INHIBIT 4'hB
`define PRC_FN_PCON 4'h3
`define PRC_TICK_NS 100000
`define PRC_CLK_NS 8
`define PRC_PHYS_N 6
`define PRC_TERM_N 4
`define PRC_PEND_W 20
`define PRC_ACC_W 32
`define PRC_ERR_W 24
`endif

/* File: core/prc_pkg.sv */
`include "prc_consts.svh"
package prc_pkg;
	typedef struct packed {
		logic order_sel_ff;
		logic order_act_ff;
		logic [14:0] tc_ff;
		logic [14:0] tc_act_ff;
		logic clr_seen_ff;
		logic ref_seen_ff;
		logic [15:0] win_ff;
		logic [15:0] settle_ff;
		logic [1:0] alloc_ff;
		logic [3:0] mode_ff;
		logic [3:0] mode_act_ff;
		logic [3:0][15:0] map_ff;
		logic [3:0][3:0] inv_ff;
		logic [5:0] src_virt_ff;
		logic [5:0] low_en_ff;
		logic [5:0] high_en_ff;
		logic [15:0] virt_ff;
		logic [15:0] tick_cnt_ff;
		logic [1:0][`PRC_PEND_W-1:0] pend_ff;
		logic [1:0][`PRC_ACC_W-1:0] acc_ff;
		logic [`PRC_ERR_W-1:0] err_ff;
		logic [16:0] settle_cnt_ff;
		logic done_n_ff;
		logic pulse_ff;
		logic dir_ff;
		logic inhibit_ff;
		logic [3:0] term_ff;
		logic [15:0] func_ff;
		logic [15:0] rdata_ff;
	} prc_state_t;
endpackage

/* File: core/prc_top.sv */
`timescale 1ns/100ps
`include "prc_consts.svh"
// Summary of operation
// - order select: 0 first-order, 1 second-order, restart
// - time constant 0..32767 in 0.1 ms
// - smoothing keeps pulse count unchanged
// - new constant after clear then new reference
// - done when error under window past settle
// - completion output low means positioning done
// - completion routed to allocated output terminal
// - proportional input on stops pulse counting
// - inhibit only in mode B, restart
// - bits 0..5 physical or virtual, nibble mapped
// - bits 6 and 7 are virtual only
// - bits 8..15 virtual, two more maps
// - per-port bus low-level enable, immediate
// - per-port bus high-level enable, immediate
module prc_top #(
	parameter int TICK_CYCLES = `PRC_TICK_NS / `PRC_CLK_NS
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [`PRC_ADDR_W-1:0] addr_in,
	input wire logic [`PRC_DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic ref_pulse_in,
	input wire logic ref_dir_in,
	input wire logic fb_pulse_in,
	input wire logic fb_dir_in,
	input wire logic position_error_clear_in,
	input wire logic [`PRC_PHYS_N-1:0] phys_in,
	output logic [`PRC_DATA_W-1:0] rdata_out,
	output logic smooth_pulse_out,
	output logic smooth_dir_out,
	output logic [`PRC_TERM_N-1:0] out_term_out,
	output logic [15:0] func_active_out
);

////////////////////////////////////////////////////////////////////////
	prc_pkg::prc_state_t s_ff;
	prc_pkg::prc_state_t nxt_s;

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	logic tick;
	logic pcon_on;
	logic inhibit;
	logic accept;
	logic in_p;
	logic in_d;
	logic out_p;
	logic out_d;
	logic lvl;
	logic act;
	logic [3:0] fsel;
	logic [15:0] func;
	logic [`PRC_PEND_W-1:0] mag;
	logic [`PRC_ERR_W-1:0] abs_err;
	logic in_win;

	always_comb begin
		nxt_s = s_ff;
		tick = (s_ff.tick_cnt_ff == TICK_LAST);
		pcon_on = 1'b0;
		inhibit = 1'b0;
		accept = 1'b0;
		in_p = 1'b0;
		in_d = 1'b0;
		out_p = 1'b0;
		out_d = 1'b0;
		lvl = 1'b0;
		act = 1'b0;
		fsel = 4'h0;
		func = 16'h0000;
		mag = '0;
		abs_err = '0;
		in_win = 1'b0;

		nxt_s.tick_cnt_ff = tick ? 16'h0000 : s_ff.tick_cnt_ff + 16'h0001;

		// register writes
		if (wr_in) begin
			if (addr_in == `PRC_A_ORDER) begin
				nxt_s.order_sel_ff = wdata_in[0];
			end else if (addr_in == `PRC_A_TC) begin
				nxt_s.tc_ff = wdata_in[14:0];
			end else if (addr_in == `PRC_A_WIN) begin
				nxt_s.win_ff = wdata_in;
			end else if (addr_in == `PRC_A_SETTLE) begin
				nxt_s.settle_ff = wdata_in;
			end else if (addr_in == `PRC_A_ALLOC) begin
				nxt_s.alloc_ff = wdata_in[1:0];
			end else if (addr_in == `PRC_A_MODE) begin
				nxt_s.mode_ff = wdata_in[3:0];
			end else if (addr_in == `PRC_A_MAP0) begin
				nxt_s.map_ff[0] = wdata_in;
			end else if (addr_in == `PRC_A_MAP1) begin
				nxt_s.map_ff[1] = wdata_in;
			end else if (addr_in == `PRC_A_MAP2) begin
				nxt_s.map_ff[2] = wdata_in;
			end else if (addr_in == `PRC_A_MAP3) begin
				nxt_s.map_ff[3] = wdata_in;
			end else if (addr_in == `PRC_A_INV0) begin
				nxt_s.inv_ff[0] = wdata_in[3:0];
			end else if (addr_in == `PRC_A_INV1) begin
				nxt_s.inv_ff[1] = wdata_in[3:0];
			end else if (addr_in == `PRC_A_INV2) begin
				nxt_s.inv_ff[2] = wdata_in[3:0];
			end else if (addr_in == `PRC_A_INV3) begin
				nxt_s.inv_ff[3] = wdata_in[3:0];
			end else if (addr_in == `PRC_A_LOWEN) begin
				nxt_s.low_en_ff = wdata_in[5:0];
			end else if (addr_in == `PRC_A_HIGHEN) begin
				nxt_s.high_en_ff = wdata_in[5:0];
			end else if (addr_in == `PRC_A_VIRT) begin
				nxt_s.virt_ff = wdata_in;
			end else if (addr_in == `PRC_A_SRC) begin
				nxt_s.src_virt_ff = wdata_in[5:0];
			end else if (addr_in == `PRC_A_RESTART) begin
				// restart-time settings become live here
				if (wdata_in[0]) begin
					nxt_s.order_act_ff = s_ff.order_sel_ff;
					nxt_s.mode_act_ff = s_ff.mode_ff;
				end
			end
		end

		// input bit mapping
		for (int i = 0; i < 16; i++) begin
			if (i < `PRC_PHYS_N && !s_ff.src_virt_ff[i]) begin
				lvl = phys_in[i];
				if (s_ff.low_en_ff[i] && !s_ff.virt_ff[i]) begin
					lvl = 1'b0;
				end
				if (s_ff.high_en_ff[i] && s_ff.virt_ff[i]) begin
					lvl = 1'b1;
				end
			end else begin
				lvl = s_ff.virt_ff[i];
			end
			act = ~lvl ^ s_ff.inv_ff[i/4][i%4];
			fsel = s_ff.map_ff[i/4][4*(i%4) +: 4];
			func[fsel] = func[fsel] | act;
		end
		nxt_s.func_ff = func;

		// pulse inhibit
		pcon_on = func[`PRC_FN_PCON];
		inhibit = (s_ff.mode_act_ff == `PRC_MODE_INHIBIT) && pcon_on;
		accept = ref_pulse_in && !inhibit;
		nxt_s.inhibit_ff = inhibit;

		// time constant hand-over
		if (position_error_clear_in) begin
			nxt_s.clr_seen_ff = 1'b1;
			nxt_s.ref_seen_ff = 1'b0;
		end else if (accept && s_ff.clr_seen_ff) begin
			nxt_s.ref_seen_ff = 1'b1;
		end
		if (s_ff.clr_seen_ff && s_ff.ref_seen_ff) begin
			nxt_s.tc_act_ff = s_ff.tc_ff;
			nxt_s.clr_seen_ff = position_error_clear_in;
			nxt_s.ref_seen_ff = 1'b0;
		end

		// smoothing stages
		in_p = accept;
		in_d = ref_dir_in;
		for (int k = 0; k < 2; k++) begin
			if (s_ff.tc_act_ff == 15'h0000 ||
			    (k == 1 && !s_ff.order_act_ff)) begin
				out_p = in_p;
				out_d = in_d;
			end else begin
				out_p = 1'b0;
				out_d = s_ff.pend_ff[k][`PRC_PEND_W-1];
				mag = out_d ? -s_ff.pend_ff[k] : s_ff.pend_ff[k];
				if (tick) begin
					// rate proportional to backlog: exponential lag
					nxt_s.acc_ff[k] = s_ff.acc_ff[k] +
					    `PRC_ACC_W'(mag);
				end
				if (mag != '0 && s_ff.acc_ff[k] >=
				    `PRC_ACC_W'(s_ff.tc_act_ff)) begin
					out_p = 1'b1;
					nxt_s.acc_ff[k] = nxt_s.acc_ff[k] -
					    `PRC_ACC_W'(s_ff.tc_act_ff);
					nxt_s.pend_ff[k] = out_d ?
					    s_ff.pend_ff[k] + 1'b1 :
					    s_ff.pend_ff[k] - 1'b1;
				end
				if (in_p) begin
					nxt_s.pend_ff[k] = in_d ?
					    nxt_s.pend_ff[k] - 1'b1 :
					    nxt_s.pend_ff[k] + 1'b1;
				end
				if (s_ff.pend_ff[k] == '0) begin
					nxt_s.acc_ff[k] = '0;
				end
			end
			in_p = out_p;
			in_d = out_d;
		end
		nxt_s.pulse_ff = out_p;
		nxt_s.dir_ff = out_d;

		// position error: commanded minus travelled
		if (position_error_clear_in) begin
			nxt_s.err_ff = '0;
		end else begin
			if (out_p) begin
				nxt_s.err_ff = out_d ? nxt_s.err_ff - 1'b1 :
				    nxt_s.err_ff + 1'b1;
			end
			if (fb_pulse_in) begin
				nxt_s.err_ff = fb_dir_in ? nxt_s.err_ff + 1'b1 :
				    nxt_s.err_ff - 1'b1;
			end
		end

		// completion detection
		abs_err = s_ff.err_ff[`PRC_ERR_W-1] ? -s_ff.err_ff : s_ff.err_ff;
		in_win = abs_err < `PRC_ERR_W'(s_ff.win_ff);
		if (!in_win) begin
			nxt_s.settle_cnt_ff = 17'h00000;
		end else if (tick &&
		    s_ff.settle_cnt_ff <= {1'b0, s_ff.settle_ff}) begin
			nxt_s.settle_cnt_ff = s_ff.settle_cnt_ff + 17'h00001;
		end
		nxt_s.done_n_ff = !(in_win &&
		    s_ff.settle_cnt_ff > {1'b0, s_ff.settle_ff});
		for (int t = 0; t < `PRC_TERM_N; t++) begin
			nxt_s.term_ff[t] = (s_ff.alloc_ff == 2'(t)) ?
			    s_ff.done_n_ff : 1'b1;
		end

		// register reads
		nxt_s.rdata_ff = 16'h0000;
		if (rd_in) begin
			if (addr_in == `PRC_A_ORDER) begin
				nxt_s.rdata_ff = {15'h0000, s_ff.order_sel_ff};
			end else if (addr_in == `PRC_A_TC) begin
				nxt_s.rdata_ff = {1'b0, s_ff.tc_ff};
			end else if (addr_in == `PRC_A_WIN) begin
				nxt_s.rdata_ff = s_ff.win_ff;
			end else if (addr_in == `PRC_A_SETTLE) begin
				nxt_s.rdata_ff = s_ff.settle_ff;
			end else if (addr_in == `PRC_A_ALLOC) begin
				nxt_s.rdata_ff = {14'h0000, s_ff.alloc_ff};
			end else if (addr_in == `PRC_A_MODE) begin
				nxt_s.rdata_ff = {12'h000, s_ff.mode_ff};
			end else if (addr_in == `PRC_A_MAP0) begin
				nxt_s.rdata_ff = s_ff.map_ff[0];
			end else if (addr_in == `PRC_A_MAP1) begin
				nxt_s.rdata_ff = s_ff.map_ff[1];
			end else if (addr_in == `PRC_A_MAP2) begin
				nxt_s.rdata_ff = s_ff.map_ff[2];
			end else if (addr_in == `PRC_A_MAP3) begin
				nxt_s.rdata_ff = s_ff.map_ff[3];
			end else if (addr_in == `PRC_A_INV0) begin
				nxt_s.rdata_ff = {12'h000, s_ff.inv_ff[0]};
			end else if (addr_in == `PRC_A_INV1) begin
				nxt_s.rdata_ff = {12'h000, s_ff.inv_ff[1]};
			end else if (addr_in == `PRC_A_INV2) begin
				nxt_s.rdata_ff = {12'h000, s_ff.inv_ff[2]};
			end else if (addr_in == `PRC_A_INV3) begin
				nxt_s.rdata_ff = {12'h000, s_ff.inv_ff[3]};
			end else if (addr_in == `PRC_A_LOWEN) begin
				nxt_s.rdata_ff = {10'h000, s_ff.low_en_ff};
			end else if (addr_in == `PRC_A_HIGHEN) begin
				nxt_s.rdata_ff = {10'h000, s_ff.high_en_ff};
			end else if (addr_in == `PRC_A_VIRT) begin
				nxt_s.rdata_ff = s_ff.virt_ff;
			end else if (addr_in == `PRC_A_SRC) begin
				nxt_s.rdata_ff = {10'h000, s_ff.src_virt_ff};
			end else if (addr_in == `PRC_A_STATUS) begin
				nxt_s.rdata_ff = {12'h000, s_ff.order_act_ff,
				    s_ff.inhibit_ff, pcon_on, ~s_ff.done_n_ff};
			end else if (addr_in == `PRC_A_ERR) begin
				nxt_s.rdata_ff = s_ff.err_ff[15:0];
			end else if (addr_in == `PRC_A_TCACT) begin
				nxt_s.rdata_ff = {1'b0, s_ff.tc_act_ff};
			end
		end
	end

////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_ff <= '0;
			s_ff.order_sel_ff <= `PRC_ORDER_DEF;
			s_ff.order_act_ff <= `PRC_ORDER_DEF;
			s_ff.tc_ff <= `PRC_TC_DEF;
			s_ff.tc_act_ff <= `PRC_TC_DEF;
			s_ff.win_ff <= `PRC_WIN_DEF;
			s_ff.settle_ff <= `PRC_SETTLE_DEF;
			s_ff.mode_ff <= `PRC_MODE_DEF;
			s_ff.mode_act_ff <= `PRC_MODE_DEF;
			s_ff.done_n_ff <= 1'b1;
			s_ff.term_ff <= {`PRC_TERM_N{1'b1}};
		end else if (ce_in) begin
			s_ff <= nxt_s;
		end
	end

	assign rdata_out = s_ff.rdata_ff;
	assign smooth_pulse_out = s_ff.pulse_ff;
	assign smooth_dir_out = s_ff.dir_ff;
	assign out_term_out = s_ff.term_ff;
	assign func_active_out = s_ff.func_ff;

endmodule

/* File: tb/prc_host_model.sv */
`timescale 1ns/100ps
module prc_host_model (
	input wire logic mclk_in,
	input wire logic go_in,
	input wire logic [7:0] n_in,
	input wire logic slow_in,
	input wire logic dir_in,
	input wire logic follow_in,
	input wire logic smooth_pulse_in,
	input wire logic smooth_dir_in,
	output logic ref_pulse_out,
	output logic ref_dir_out,
	output logic fb_pulse_out,
	output logic fb_dir_out,
	output logic busy_out
);
	logic [7:0] left;
	logic [1:0] gap;
	initial begin
		{ref_pulse_out, ref_dir_out, fb_pulse_out, fb_dir_out} = 4'h0;
		{left, gap} = 10'h000;
	end
	assign busy_out = left != 8'h00;
	////////////////////////////////////////
	// idle ref direction toggles, fb direction too while follow_in is off, so no stale level is read
	always @(posedge mclk_in) begin
		fb_pulse_out <= follow_in & smooth_pulse_in;
		fb_dir_out <= follow_in ? smooth_dir_in : ~fb_dir_out;
		ref_pulse_out <= 1'b0;
		ref_dir_out <= ~ref_dir_out;
		if (go_in && !busy_out) begin
			left <= n_in;
		end else if (busy_out && gap != 2'h0) begin
			gap <= gap - 2'h1;
		end else if (busy_out) begin
			ref_pulse_out <= 1'b1;
			ref_dir_out <= dir_in;
			left <= left - 8'h01;
			gap <= {slow_in, slow_in};
		end
	end
endmodule

/* File: tb/prc_top_monitor.sv */
`timescale 1ns/100ps
`include "prc_consts.svh"
module prc_monitor (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [`PRC_ADDR_W-1:0] addr_in,
	input wire logic rd_in,
	input wire logic [`PRC_DATA_W-1:0] rdata_out,
	input wire logic smooth_pulse_out,
	input wire logic [`PRC_TERM_N-1:0] out_term_out,
	input wire logic [15:0] func_active_out
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);
	logic rq;
	assign rq = rd_in & ce_in;
	////////////////////////////////////////
	property p_idle;
		ce_in && !rd_in |=> rdata_out == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_unmap;
		rq && addr_in > 5'h15 |=> rdata_out == 16'h0000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_order;
		rq && addr_in == `PRC_A_ORDER |=> rdata_out[15:1] == 15'h0000;
	endproperty
	a_order: assert property (p_order) else $error("order width");
	property p_tc;
		rq && addr_in == `PRC_A_TC |=> !rdata_out[15];
	endproperty
	a_tc: assert property (p_tc) else $error("tc width");
	property p_mode;
		rq && addr_in == `PRC_A_MODE |=> rdata_out[15:4] == 12'h000;
	endproperty
	a_mode: assert property (p_mode) else $error("mode width");
	property p_alloc;
		rq && addr_in == `PRC_A_ALLOC |=> rdata_out[15:2] == 14'h0000;
	endproperty
	a_alloc: assert property (p_alloc) else $error("alloc width");
	property p_term;
		$countones(out_term_out) >= 3;
	endproperty
	a_term: assert property (p_term) else $error("two terms low");
	property p_freeze;
		!ce_in |=> $stable(out_term_out) && $stable(func_active_out)
			&& $stable(smooth_pulse_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("moved while held");
endmodule
bind prc_top prc_monitor i_mon (.mclk_in, .resetn_in, .ce_in, .addr_in,
	.rd_in, .rdata_out, .smooth_pulse_out, .out_term_out, .func_active_out);

/* File: tb/prc_top_tb.sv */
`timescale 1ns/100ps
`include "prc_consts.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	n_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module prc_top_tb;
	logic clk, resetn, ce, wr, rd, clr, go, dir, fol, slow, busy, rseen;
	logic rp, rdr, fp, fdr, sp, sdr;
	logic [4:0] addr;
	logic [15:0] wd, rdat, fa;
	logic [5:0] phys;
	logic [3:0] term;
	logic [7:0] n;
	logic [31:0] q[$];
	logic [31:0] rs;
	int n_errors, comparisons, n_sm, tot, cyc;
	prc_top #(.TICK_CYCLES(4)) i_dut (.mclk_in(clk), .resetn_in(resetn),
		.ce_in(ce), .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
		.ref_pulse_in(rp), .ref_dir_in(rdr), .fb_pulse_in(fp),
		.fb_dir_in(fdr), .position_error_clear_in(clr), .phys_in(phys),
		.rdata_out(rdat), .smooth_pulse_out(sp), .smooth_dir_out(sdr),
		.out_term_out(term), .func_active_out(fa));
	prc_host_model i_host (.mclk_in(clk), .go_in(go), .n_in(n),
		.slow_in(slow), .dir_in(dir), .follow_in(fol), .smooth_pulse_in(sp),
		.smooth_dir_in(sdr), .ref_pulse_out(rp), .ref_dir_out(rdr),
		.fb_pulse_out(fp), .fb_dir_out(fdr), .busy_out(busy));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic end_sim;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	////////////////////////////////////////
	always @(posedge clk) begin
		if (rseen) begin
			`CHK("rdata", q[0][15:0], rdat & q[0][31:16])
			void'(q.pop_front());
		end
		rseen <= rd;
		n_sm += int'(sp === 1'b1);
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rd_reg(input logic [4:0] a, input logic [15:0] m, e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		q.push_back({m, e & m});
		@(posedge clk);
		rd <= 0;
	endtask
	task automatic pulse_clr;
		@(posedge clk);
		clr <= 1;
		@(posedge clk);
		clr <= 0;
	endtask
	task automatic send(input int k, input logic f, s, d);
		@(posedge clk);
		n <= 8'(k);
		{fol, slow, dir, go} <= {f, s, d, 1'b1};
		tot += k;
		@(posedge clk);
		go <= 0;
		@(negedge clk);
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
	endtask
	task automatic wait_cnt(input int e);
		for (int i = 0; i < 3000 && n_sm != e; i++) @(negedge clk);
		repeat (100) @(negedge clk);
		`CHK("pulses", e, n_sm)
	endtask
	task automatic wait_term(input logic [3:0] e);
		for (int i = 0; i < 300 && term !== e; i++) @(negedge clk);
		`CHK("term", e, term)
	endtask
	task automatic chk_fa(input int b, input logic e);
		repeat (4) @(negedge clk);
		`CHK("func", e, fa[b])
	endtask
	////////////////////////////////////////
	initial begin
		{resetn, wr, rd, clr, go, dir, fol, slow, rseen} = 9'h000;
		{addr, wd, n} = 29'h0;
		ce = 1;
		phys = 6'h3F;
		rs = 32'h00006398;
		repeat (6) @(posedge clk);
		resetn <= 1;
		rd_reg(`PRC_A_ORDER, 16'hFFFF, {15'h0000, `PRC_ORDER_DEF});
		rd_reg(`PRC_A_WIN, 16'hFFFF, `PRC_WIN_DEF);
		rd_reg(`PRC_A_SETTLE, 16'hFFFF, `PRC_SETTLE_DEF);
		rd_reg(5'h1F, 16'hFFFF, 16'h0000);
		wr_reg(`PRC_A_SETTLE, 16'h0002);
		wr_reg(`PRC_A_ALLOC, 16'h0001);
		rd_reg(`PRC_A_ALLOC, 16'hFFFF, 16'h0001);
		wait_term(4'hD);
		send(10, 0, 0, 0);
		wait_cnt(tot);
		wait_term(4'hF);
		rd_reg(`PRC_A_ERR, 16'hFFFF, 16'h000A);
		ce <= 0;
		repeat (3) @(posedge clk);
		ce <= 1;
		pulse_clr();
		wait_term(4'hD);
		wr_reg(`PRC_A_TC, 16'h7FFF);
		rd_reg(`PRC_A_TC, 16'hFFFF, 16'h7FFF);
		wr_reg(`PRC_A_TC, 16'h0003);
		rd_reg(`PRC_A_TCACT, 16'hFFFF, 16'h0000);
		pulse_clr();
		send(1, 1, 1, 0);
		// active copy lands two edges after the accepted pulse
		repeat (2) @(posedge clk);
		rd_reg(`PRC_A_TCACT, 16'hFFFF, 16'h0003);
		rs = xs(rs);
		send(int'(rs[4:0]) + 2, 1, 0, rs[8]);
		wait_cnt(tot);
		wait_term(4'hD);
		wr_reg(`PRC_A_MAP0, 16'h0053);
		wr_reg(`PRC_A_SRC, 16'h0001);
		wr_reg(`PRC_A_VIRT, 16'h0000);
		wr_reg(`PRC_A_ORDER, 16'h0001);
		wr_reg(`PRC_A_MODE, {12'h000, `PRC_MODE_INHIBIT});
		rd_reg(`PRC_A_MODE, 16'hFFFF, {12'h000, `PRC_MODE_INHIBIT});
		chk_fa(3, 1);
		send(3, 1, 0, 0);
		wait_cnt(tot);
		rd_reg(`PRC_A_STATUS, 16'h000C, 16'h0000);
		wr_reg(`PRC_A_RESTART, 16'h0001);
		rd_reg(`PRC_A_STATUS, 16'h000E, 16'h000E);
		send(5, 1, 0, 0);
		tot -= 5;
		wait_cnt(tot);
		wr_reg(`PRC_A_VIRT, 16'h0001);
		chk_fa(3, 0);
		send(4, 1, 0, 0);
		wait_cnt(tot);
		wr_reg(`PRC_A_INV0, 16'h0001);
		chk_fa(3, 1);
		rs = xs(rs);
		@(posedge clk);
		phys <= rs[5:0] | 6'h02;
		chk_fa(5, 0);
		wr_reg(`PRC_A_LOWEN, 16'h0002);
		chk_fa(5, 1);
		wr_reg(`PRC_A_LOWEN, 16'h0000);
		phys <= rs[5:0] & 6'h3D;
		chk_fa(5, 1);
		wr_reg(`PRC_A_VIRT, 16'h0003);
		wr_reg(`PRC_A_HIGHEN, 16'h0002);
		chk_fa(5, 0);
		// bit6 to function 6, bit8 to function 7, both virtual only
		wr_reg(`PRC_A_MAP1, 16'h0600);
		wr_reg(`PRC_A_MAP2, 16'h0007);
		chk_fa(6, 1);
		chk_fa(7, 1);
		wr_reg(`PRC_A_VIRT, 16'h0143);
		chk_fa(6, 0);
		chk_fa(7, 0);
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule
